// ==== core/pfs_pkg.sv ====
// Purpose: Shared constants and types of the power fault status block
// Assumes: Both link ends and the host controller use this package
// Notes: Limits are raw codes; volts 1 V, levels 0.1 V, amps 0.1 A, ms 1 ms
//
// How it works
// R01: Temp warning 25..125, below fault threshold
// R02: Input overvoltage threshold 48..90, compared with input
// R03: Reaction 11 holds output off, 10 shuts
// R04: Retry field fixed 000, no restart
// R05: Delay field fixed zero, immediate shutdown
// R06: Reaction 7:6, retry 5:3, delay 2:0; bit6 writable
// R07: Power-good levels 8.1..13.2, gap 1.6 V
// R08: Turn-on delay 0..500 ms before ramp
// R09: Ramp time 15..500 ms to setpoint
// R10: Summary upper byte: bits 15,14,13,11 only
// R11: Summary lower byte: bits 6..1 only
// R12: Vout status bit7; iout bits 7,5; clearable
// R13: Temp fault threshold 25..140, above warning
// R14: Current warning 7.6..30.3, below fault; flags
// R15: Summary bits follow detailed status bits
// R16: Unsupported bits read zero, read-only writes ignored
package pfs_pkg;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_IOC_WARN = 8'h4a;
  localparam logic [7:0] CMD_OT_FAULT = 8'h4f;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_VIN_OV = 8'h55;
  localparam logic [7:0] CMD_VIN_RSP = 8'h56;
  localparam logic [7:0] CMD_PG_ON = 8'h5e;
  localparam logic [7:0] CMD_PG_OFF = 8'h5f;
  localparam logic [7:0] CMD_TON_DLY = 8'h60;
  localparam logic [7:0] CMD_OUTPUT_RAMP_TIME = 8'h61;
  localparam logic [7:0] CMD_SUMMARY = 8'h79;
  localparam logic [7:0] CMD_VOUT_ST = 8'h7a;
  localparam logic [7:0] CMD_IOUT_ST = 8'h7b;
  // ****************************************
  // Range limits
  // ****************************************
  localparam logic [15:0] OTW_MIN = 16'h0019;
  localparam logic [15:0] OTW_MAX = 16'h007d;
  localparam logic [15:0] OTF_MAX = 16'h008c;
  localparam logic [15:0] VINOV_MIN = 16'h0030;
  localparam logic [15:0] VINOV_MAX = 16'h005a;
  localparam logic [15:0] PG_MIN = 16'h0051;
  localparam logic [15:0] PG_MAX = 16'h0084;
  localparam logic [16:0] PG_GAP = 17'h00010;
  localparam logic [15:0] TON_MAX = 16'h01f4;
  localparam logic [15:0] RISE_MIN = 16'h000f;
  localparam logic [15:0] RISE_MAX = 16'h01f4;
  localparam logic [15:0] IOCW_MIN = 16'h004c;
  localparam logic [15:0] IOCW_MAX = 16'h012f;
  localparam logic [15:0] IOC_FAULT_LIMIT = 16'h01c7;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] OTW_RESET = 16'h006e;
  localparam logic [15:0] OTF_RESET = 16'h007d;
  localparam logic [15:0] VINOV_RESET = 16'h0050;
  localparam logic [15:0] PGON_RESET = 16'h006e;
  localparam logic [15:0] PGOFF_RESET = 16'h005a;
  localparam logic [15:0] TDLY_RESET = 16'h000a;
  localparam logic [15:0] TRISE_RESET = 16'h000f;
  localparam logic [15:0] IOCW_RESET = 16'h00fa;
  localparam logic [7:0] RSP_RESET = 8'hc0;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int RSP_HI = 7;
  localparam int RSP_WR = 6;
  localparam logic [1:0] REACT_HOLD = 2'h3;
  localparam logic [1:0] REACT_SHUT = 2'h2;
  localparam int SW_VOUT = 15;
  localparam int SW_LOAD = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_PNG = 11;
  localparam int SW_OFF = 6;
  localparam int SW_VOV = 5;
  localparam int SW_IOC = 4;
  localparam int SW_VUV = 3;
  localparam int SW_TEMP = 2;
  localparam int SW_CML = 1;
  localparam int ST_FAULT = 7;
  localparam int ST_WARN = 5;
  // ****************************************
  // Link framing
  // ****************************************
  localparam int FRAME_BITS = 26;
  localparam logic [4:0] RD_LOAD_BIT = 5'h09;
  localparam logic [4:0] LAST_RX_BIT = 5'h19;
  localparam int LINK_HALF = 8;
  // ****************************************
  // Host registers
  // ****************************************
  localparam logic [3:0] A_CMD = 4'h0;
  localparam logic [3:0] A_RESULT = 4'h4;
  localparam logic [3:0] A_IRQ_ST = 4'h8;
  localparam logic [3:0] A_IRQ_MASK = 4'hc;
  localparam int CMD_RD_BIT = 8;
  localparam int RES_ACK = 16;
  localparam int RES_BUSY = 17;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NACK = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 125000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  // ****************************************
  // States
  // ****************************************
  typedef enum logic [2:0] {
    SEQ_OFF = 3'b000,
    SEQ_DELAY = 3'b001,
    SEQ_RAMP = 3'b010,
    SEQ_ON = 3'b011,
    SEQ_HOLD = 3'b100,
    SEQ_LATCH = 3'b101
  } pfs_seq_t;
  typedef enum logic [1:0] {
    LNK_IDLE = 2'b00,
    LNK_LOW = 2'b01,
    LNK_HIGH = 2'b10,
    LNK_GAP = 2'b11
  } pfs_link_t;
endpackage : pfs_pkg

// ==== core/pfs_link_if.sv ====
// Purpose: Serial link between host controller and power fault device
// Assumes: Host drives clock, select and data out; device drives reply
// Notes: No two-way pins; no clocking block
`timescale 1ns/10ps
interface pfs_link_if;
  logic lclk;
  logic lsel;
  logic ldo;
  logic ldi;
  modport host (output lclk, output lsel, output ldo, input ldi);
  modport device (input lclk, input lsel, input ldo, output ldi);
endinterface : pfs_link_if

// ==== core/pfs_device.sv ====
// Purpose: Command registers, status and turn-on sequencing of the module
// Assumes: User-side levels and events are on aclk; link pins are not
// Notes: Frame is rw, code, 16 data bits, then one reply bit
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
module pfs_device #(
  parameter int MS_CYCLES = pfs_pkg::MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  pfs_link_if.device link,
  input wire logic enable,
  input wire logic [15:0] vin_level,
  input wire logic [15:0] temp_level,
  input wire logic [15:0] iout_level,
  input wire logic [15:0] vout_level,
  input wire logic vout_ov_event,
  input wire logic iout_oc_event,
  input wire logic input_undervoltage_flag,
  output logic output_on,
  output logic ramping,
  output logic power_good,
  output logic [15:0] summary_status
);
  if (MS_CYCLES < 2) begin : g_bad_ms
    $error("MS_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [2:0] ff1;
    logic [2:0] ff2;
    logic clk_d;
    logic [4:0] bitn;
    logic [23:0] rxs;
    logic [15:0] txs;
    logic rd_ok;
    logic ldi;
    logic [15:0] otw;
    logic [15:0] otf;
    logic [15:0] vinov;
    logic rsp0;
    logic [15:0] pgon;
    logic [15:0] pgoff;
    logic [15:0] tdly;
    logic [15:0] trise;
    logic [15:0] iocw;
    logic output_overvoltage_flag;
    logic output_overcurrent_flag;
    logic output_current_warning_flag;
    logic comm_logic_fault_flag;
    logic pg;
    pfs_pkg::pfs_seq_t seq;
    logic [31:0] pre;
    logic [15:0] ms;
  } pfs_dev_t;

  pfs_dev_t q;
  pfs_dev_t next_q;
  logic rise;
  logic fall;
  logic [24:0] frm;
  logic [15:0] d;
  logic [15:0] rdv;
  logic rdok;
  logic wok;
  logic vin_ov;
  logic [1:0] react;
  logic [15:0] sw;
  logic [7:0] vst;
  logic [7:0] ist;

  // ****************************************
  // Status words
  // ****************************************
  always_comb begin
    react = {1'b1, q.rsp0};
    vin_ov = vin_level > q.vinov; // R02
    vst = 8'(q.output_overvoltage_flag) << pfs_pkg::ST_FAULT; // R12 R16
    ist = (8'(q.output_overcurrent_flag) << pfs_pkg::ST_FAULT)
        | (8'(q.output_current_warning_flag) << pfs_pkg::ST_WARN); // R12
    sw = '0; // R16
    sw[pfs_pkg::SW_VOUT] = |vst; // R10 R15
    sw[pfs_pkg::SW_LOAD] = |ist; // R10 R15
    sw[pfs_pkg::SW_INPUT] = vin_ov | (q.seq == pfs_pkg::SEQ_LATCH); // R10
    sw[pfs_pkg::SW_PNG] = ~q.pg; // R10
    sw[pfs_pkg::SW_OFF] = q.seq != pfs_pkg::SEQ_ON; // R11
    sw[pfs_pkg::SW_VOV] = q.output_overvoltage_flag; // R11
    sw[pfs_pkg::SW_IOC] = q.output_overcurrent_flag; // R11
    sw[pfs_pkg::SW_VUV] = input_undervoltage_flag; // R11
    sw[pfs_pkg::SW_TEMP] = temp_level >= q.otw; // R11
    sw[pfs_pkg::SW_CML] = q.comm_logic_fault_flag; // R11
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_q = q;
    next_q.ff1 = {link.lclk, link.lsel, link.ldo};
    next_q.ff2 = q.ff1;
    next_q.clk_d = q.ff2[2];
    rise = q.ff2[2] & ~q.clk_d;
    fall = ~q.ff2[2] & q.clk_d;
    frm = {q.rxs, q.ff2[0]};
    d = frm[15:0];
    rdok = 1'b1;
    case (frm[7:0])
      pfs_pkg::CMD_IOC_WARN: rdv = q.iocw;
      pfs_pkg::CMD_OT_FAULT: rdv = q.otf;
      pfs_pkg::CMD_OT_WARN: rdv = q.otw;
      pfs_pkg::CMD_VIN_OV: rdv = q.vinov;
      pfs_pkg::CMD_VIN_RSP: rdv = {8'h00, react, 6'h00}; // R04 R05 R06
      pfs_pkg::CMD_PG_ON: rdv = q.pgon;
      pfs_pkg::CMD_PG_OFF: rdv = q.pgoff;
      pfs_pkg::CMD_TON_DLY: rdv = q.tdly;
      pfs_pkg::CMD_OUTPUT_RAMP_TIME: rdv = q.trise;
      pfs_pkg::CMD_SUMMARY: rdv = sw;
      pfs_pkg::CMD_VOUT_ST: rdv = {8'h00, vst};
      pfs_pkg::CMD_IOUT_ST: rdv = {8'h00, ist};
      default: begin
        rdv = '0;
        rdok = 1'b0;
      end
    endcase
    wok = 1'b0;
    if (!q.ff2[1]) begin
      next_q.bitn = '0;
      next_q.ldi = 1'b0;
    end else if (rise) begin
      next_q.bitn = q.bitn + 5'h01;
      next_q.rxs = frm[23:0];
      if (next_q.bitn == pfs_pkg::RD_LOAD_BIT) begin
        next_q.txs = rdv;
        next_q.rd_ok = rdok;
        if (!rdok) next_q.comm_logic_fault_flag = 1'b1;
      end
      if (next_q.bitn == pfs_pkg::LAST_RX_BIT) begin
        if (frm[24]) begin
          wok = q.rd_ok;
        end else begin
          case (frm[23:16])
            pfs_pkg::CMD_OT_WARN: begin
              wok = d >= pfs_pkg::OTW_MIN && d <= pfs_pkg::OTW_MAX
                  && d < q.otf; // R01
              if (wok) next_q.otw = d;
            end
            pfs_pkg::CMD_OT_FAULT: begin
              wok = d >= pfs_pkg::OTW_MIN && d <= pfs_pkg::OTF_MAX
                  && d > q.otw; // R13
              if (wok) next_q.otf = d;
            end
            pfs_pkg::CMD_VIN_OV: begin
              wok = d >= pfs_pkg::VINOV_MIN && d <= pfs_pkg::VINOV_MAX; // R02
              if (wok) next_q.vinov = d;
            end
            pfs_pkg::CMD_VIN_RSP: begin
              wok = 1'b1;
              next_q.rsp0 = d[pfs_pkg::RSP_WR]; // R06 R16
            end
            pfs_pkg::CMD_PG_ON: begin
              wok = d >= pfs_pkg::PG_MIN && d <= pfs_pkg::PG_MAX
                  && {1'b0, d} >= {1'b0, q.pgoff} + pfs_pkg::PG_GAP; // R07
              if (wok) next_q.pgon = d;
            end
            pfs_pkg::CMD_PG_OFF: begin
              wok = d >= pfs_pkg::PG_MIN && d <= pfs_pkg::PG_MAX
                  && {1'b0, d} + pfs_pkg::PG_GAP <= {1'b0, q.pgon}; // R07
              if (wok) next_q.pgoff = d;
            end
            pfs_pkg::CMD_TON_DLY: begin
              wok = d <= pfs_pkg::TON_MAX; // R08
              if (wok) next_q.tdly = d;
            end
            pfs_pkg::CMD_OUTPUT_RAMP_TIME: begin
              wok = d >= pfs_pkg::RISE_MIN && d <= pfs_pkg::RISE_MAX; // R09
              if (wok) next_q.trise = d;
            end
            pfs_pkg::CMD_IOC_WARN: begin
              wok = d >= pfs_pkg::IOCW_MIN && d <= pfs_pkg::IOCW_MAX
                  && d < pfs_pkg::IOC_FAULT_LIMIT; // R14
              if (wok) next_q.iocw = d;
            end
            pfs_pkg::CMD_VOUT_ST: begin
              wok = 1'b1;
              if (d[pfs_pkg::ST_FAULT]) next_q.output_overvoltage_flag = 1'b0;
            end
            pfs_pkg::CMD_IOUT_ST: begin
              wok = 1'b1;
              if (d[pfs_pkg::ST_FAULT]) next_q.output_overcurrent_flag = 1'b0;
              if (d[pfs_pkg::ST_WARN]) begin
                next_q.output_current_warning_flag = 1'b0;
              end
            end
            default: wok = 1'b0;
          endcase
          if (!wok) next_q.comm_logic_fault_flag = 1'b1;
        end
        next_q.txs = {wok, 15'h0000};
      end
    end else if (fall) begin
      next_q.ldi = q.txs[15];
      next_q.txs = {q.txs[14:0], 1'b0};
    end
    // Hardware sets win over host clears
    if (vout_ov_event) next_q.output_overvoltage_flag = 1'b1; // R12
    if (iout_oc_event) next_q.output_overcurrent_flag = 1'b1; // R12
    if (iout_level > q.iocw) next_q.output_current_warning_flag = 1'b1; // R14
    // Millisecond timebase
    if (q.pre == 32'(MS_CYCLES - 1)) begin
      next_q.pre = '0;
      next_q.ms = q.ms + 16'h0001;
    end else begin
      next_q.pre = q.pre + 32'h1;
    end
    case (q.seq)
      pfs_pkg::SEQ_OFF: if (enable) next_q.seq = pfs_pkg::SEQ_DELAY;
      pfs_pkg::SEQ_DELAY: if (q.ms >= q.tdly) begin
        next_q.seq = pfs_pkg::SEQ_RAMP; // R08
      end
      pfs_pkg::SEQ_RAMP: if (q.ms >= q.trise) begin
        next_q.seq = pfs_pkg::SEQ_ON; // R09
      end
      pfs_pkg::SEQ_ON: next_q.seq = pfs_pkg::SEQ_ON;
      pfs_pkg::SEQ_HOLD: if (!vin_ov) next_q.seq = pfs_pkg::SEQ_DELAY; // R03
      pfs_pkg::SEQ_LATCH: next_q.seq = pfs_pkg::SEQ_LATCH; // R04
      default: next_q.seq = pfs_pkg::SEQ_OFF;
    endcase
    if (vin_ov && q.seq != pfs_pkg::SEQ_OFF
        && q.seq != pfs_pkg::SEQ_LATCH) begin
      // No delay field: shutdown acts at once
      next_q.seq = (react == pfs_pkg::REACT_HOLD) ? pfs_pkg::SEQ_HOLD
                 : pfs_pkg::SEQ_LATCH; // R03 R05
    end
    if (!enable) next_q.seq = pfs_pkg::SEQ_OFF;
    if (next_q.seq != q.seq) begin
      next_q.pre = '0;
      next_q.ms = '0;
    end
    if (q.seq != pfs_pkg::SEQ_ON) begin
      next_q.pg = 1'b0;
    end else if (vout_level >= q.pgon) begin
      next_q.pg = 1'b1; // R07
    end else if (vout_level < q.pgoff) begin
      next_q.pg = 1'b0; // R07
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.otw <= pfs_pkg::OTW_RESET;
      q.otf <= pfs_pkg::OTF_RESET;
      q.vinov <= pfs_pkg::VINOV_RESET;
      q.rsp0 <= pfs_pkg::RSP_RESET[pfs_pkg::RSP_WR]; // R06
      q.pgon <= pfs_pkg::PGON_RESET;
      q.pgoff <= pfs_pkg::PGOFF_RESET;
      q.tdly <= pfs_pkg::TDLY_RESET;
      q.trise <= pfs_pkg::TRISE_RESET;
      q.iocw <= pfs_pkg::IOCW_RESET;
      q.seq <= pfs_pkg::SEQ_OFF;
    end else begin
      q <= next_q;
    end
  end

  assign link.ldi = q.ldi;
  assign output_on = q.seq == pfs_pkg::SEQ_ON;
  assign ramping = q.seq == pfs_pkg::SEQ_RAMP;
  assign power_good = q.pg;
  assign summary_status = sw;
endmodule : pfs_device

// ==== core/pfs_host.sv ====
// Purpose: Link controller for the power device, commanded over AXI4-Lite
// Assumes: One link frame at a time; software polls or takes the interrupt
// Notes: Link clock comes from a divider of aclk
`timescale 1ns/10ps
module pfs_host #(
  parameter int HALF = pfs_pkg::LINK_HALF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  pfs_link_if.host link
);
  if (HALF < 6 || HALF > 255) begin : g_bad_half
    $error("HALF must lie in 6..255");
  end

  typedef struct packed {
    logic ff1;
    logic ff2;
    pfs_pkg::pfs_link_t st;
    logic [7:0] cnt;
    logic [4:0] bitn;
    logic [24:0] txs;
    logic [16:0] rxs;
    logic lclk;
    logic lsel;
    logic ldo;
    logic [15:0] rdata;
    logic ack;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rd;
    logic [1:0] rresp;
  } pfs_host_t;

  pfs_host_t q;
  pfs_host_t next_q;
  logic wr;
  logic half_done;
  logic [1:0] ev;
  logic [1:0] clr;

  assign wr = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
  assign s_axi_awready = wr;
  assign s_axi_wready = wr;
  assign s_axi_arready = ~q.rvalid;

  always_comb begin
    next_q = q;
    next_q.ff1 = link.ldi;
    next_q.ff2 = q.ff1;
    half_done = q.cnt == 8'(HALF - 1);
    next_q.cnt = half_done ? 8'h00 : q.cnt + 8'h01;
    ev = '0;
    clr = '0;
    // ****************************************
    // Register writes
    // ****************************************
    if (q.bvalid && s_axi_bready) next_q.bvalid = 1'b0;
    if (wr) begin
      next_q.bvalid = 1'b1;
      next_q.bresp = pfs_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        pfs_pkg::A_CMD: if (q.st == pfs_pkg::LNK_IDLE && &s_axi_wstrb) begin
          next_q.txs = {s_axi_wdata[pfs_pkg::CMD_RD_BIT], s_axi_wdata[7:0],
                        s_axi_wdata[31:16]};
          next_q.st = pfs_pkg::LNK_LOW;
          next_q.cnt = '0;
          next_q.bitn = '0;
          next_q.lsel = 1'b1;
          next_q.ldo = s_axi_wdata[pfs_pkg::CMD_RD_BIT];
        end
        pfs_pkg::A_RESULT: next_q.bresp = pfs_pkg::RESP_OKAY;
        pfs_pkg::A_IRQ_ST: if (s_axi_wstrb[0]) clr = s_axi_wdata[1:0];
        pfs_pkg::A_IRQ_MASK: if (s_axi_wstrb[0]) begin
          next_q.irq_mask = s_axi_wdata[1:0];
        end
        default: next_q.bresp = pfs_pkg::RESP_SLVERR;
      endcase
    end
    // ****************************************
    // Register reads
    // ****************************************
    if (q.rvalid && s_axi_rready) next_q.rvalid = 1'b0;
    if (s_axi_arvalid && !q.rvalid) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = pfs_pkg::RESP_OKAY;
      next_q.rd = '0;
      case (s_axi_araddr)
        pfs_pkg::A_CMD: next_q.rd = {q.txs[15:0], 7'h00, q.txs[24:16]};
        pfs_pkg::A_RESULT: begin
          next_q.rd[15:0] = q.rdata;
          next_q.rd[pfs_pkg::RES_ACK] = q.ack;
          next_q.rd[pfs_pkg::RES_BUSY] = q.st != pfs_pkg::LNK_IDLE;
        end
        pfs_pkg::A_IRQ_ST: next_q.rd[1:0] = q.irq_st;
        pfs_pkg::A_IRQ_MASK: next_q.rd[1:0] = q.irq_mask;
        default: next_q.rresp = pfs_pkg::RESP_SLVERR;
      endcase
    end
    // ****************************************
    // Link sequencer
    // ****************************************
    case (q.st)
      pfs_pkg::LNK_IDLE: next_q.cnt = '0;
      pfs_pkg::LNK_LOW: if (half_done) begin
        next_q.lclk = 1'b1;
        next_q.rxs = {q.rxs[15:0], q.ff2};
        next_q.st = pfs_pkg::LNK_HIGH;
      end
      pfs_pkg::LNK_HIGH: if (half_done) begin
        next_q.lclk = 1'b0;
        next_q.bitn = q.bitn + 5'h01;
        next_q.txs = {q.txs[23:0], 1'b0};
        next_q.ldo = q.txs[23];
        next_q.st = pfs_pkg::LNK_LOW;
        if (q.bitn == 5'(pfs_pkg::FRAME_BITS - 1)) begin
          next_q.lsel = 1'b0;
          next_q.ldo = 1'b0;
          next_q.st = pfs_pkg::LNK_GAP;
        end
      end
      pfs_pkg::LNK_GAP: if (half_done) begin
        next_q.rdata = q.rxs[16:1];
        next_q.ack = q.rxs[0];
        ev[pfs_pkg::IRQ_DONE] = 1'b1;
        ev[pfs_pkg::IRQ_NACK] = ~q.rxs[0];
        next_q.st = pfs_pkg::LNK_IDLE;
      end
      default: next_q.st = pfs_pkg::LNK_IDLE;
    endcase
    // Set wins over write-one-to-clear
    next_q.irq_st = (q.irq_st & ~clr) | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= pfs_pkg::LNK_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rresp;
  assign irq = |(q.irq_st & q.irq_mask);
  assign link.lclk = q.lclk;
  assign link.lsel = q.lsel;
  assign link.ldo = q.ldo;
endmodule : pfs_host

// ==== verif/pfs_chk.sv ====
// Purpose: Link wire checks for the power fault status block
// Assumes: Host half period of 8 aclk cycles
// Notes: Sees only the link signals
`timescale 1ns/10ps
module pfs_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lclk,
  input wire logic lsel,
  input wire logic ldo,
  input wire logic ldi
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [5:0] rises;
  // ****************
  // Link timing
  // ****************
  always_ff @(posedge aclk)
    if (!aresetn || !lsel) rises <= 6'h00;
    else if ($rose(lclk)) rises <= rises + 6'h01;
  a_idle_clk_low: assert property (!lsel |-> !lclk)
    else $error("link clock active outside frame");
  a_first_half: assert property ($rose(lsel) |-> !lclk [*8] ##1 lclk)
    else $error("first link clock rise misplaced");
  a_high_half: assert property ($rose(lclk) |-> lclk [*8] ##1 !lclk)
    else $error("link clock high phase wrong");
  a_low_half: assert property ($fell(lclk) && lsel |-> !lclk [*8] ##1 lclk)
    else $error("link clock low phase wrong");
  a_ldo_hold: assert property (lclk && $past(lclk) |-> $stable(ldo))
    else $error("host data moved while clock high");
  a_ldi_hold: assert property (lclk && $past(lclk) |-> $stable(ldi))
    else $error("device data moved while clock high");
  a_frame_len: assert property ($fell(lsel) |-> rises == 6'h1a)
    else $error("frame pulse count wrong");
  a_frame_gap: assert property ($fell(lsel) |-> !lsel [*8])
    else $error("frames too close");
endmodule : pfs_chk

// ==== verif/pfs_tb.sv ====
// Purpose: Self-checking bench for both link ends
// Assumes: Host half period 8; device ms of 20 cycles
// Notes: Row table of link frames, then hand-written cases
`timescale 1ns/10ps
module power_fault_status_regs_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic enable = 1'b0, vout_ev = 1'b0, iout_ev = 1'b0, uv = 1'b0;
  logic [15:0] vin = 16'h0000, iout = 16'h0000, summary;
  logic [15:0] temp = 16'h0000, vout = 16'h0000;
  logic output_on, ramping, power_good;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  // Row: read, code, data, ack
  logic [25:0] rows [38] = '{
    {1'b0,8'h51,16'h0019,1'b1}, {1'b0,8'h51,16'h0018,1'b0},
    {1'b0,8'h51,16'h007d,1'b0}, {1'b1,8'h51,16'h0019,1'b1},
    {1'b0,8'h4f,16'h008c,1'b1}, {1'b0,8'h4f,16'h008d,1'b0},
    {1'b0,8'h51,16'h007d,1'b1}, {1'b0,8'h4f,16'h007d,1'b0},
    {1'b0,8'h55,16'h002f,1'b0}, {1'b0,8'h55,16'h005b,1'b0},
    {1'b0,8'h55,16'h005a,1'b1}, {1'b1,8'h55,16'h005a,1'b1},
    {1'b0,8'h56,16'h00bf,1'b1}, {1'b1,8'h56,16'h0080,1'b1},
    {1'b0,8'h56,16'h0040,1'b1}, {1'b1,8'h56,16'h00c0,1'b1},
    {1'b0,8'h5f,16'h005f,1'b0}, {1'b0,8'h5f,16'h005e,1'b1},
    {1'b0,8'h5e,16'h0085,1'b0}, {1'b0,8'h5f,16'h0050,1'b0},
    {1'b0,8'h5e,16'h0084,1'b1}, {1'b1,8'h5e,16'h0084,1'b1},
    {1'b0,8'h60,16'h01f5,1'b0}, {1'b0,8'h60,16'h01f4,1'b1},
    {1'b0,8'h60,16'h0000,1'b1}, {1'b0,8'h61,16'h000e,1'b0},
    {1'b0,8'h61,16'h01f5,1'b0}, {1'b0,8'h61,16'h01f4,1'b1},
    {1'b0,8'h61,16'h000f,1'b1}, {1'b1,8'h61,16'h000f,1'b1},
    {1'b0,8'h4a,16'h004b,1'b0}, {1'b0,8'h4a,16'h0130,1'b0},
    {1'b0,8'h4a,16'h004c,1'b1}, {1'b1,8'h4a,16'h004c,1'b1},
    {1'b0,8'h79,16'h0000,1'b0}, {1'b1,8'h79,16'h0842,1'b1},
    {1'b1,8'h00,16'h0000,1'b0}, {1'b1,8'h5f,16'h005e,1'b1}};
  pfs_link_if link ();
  pfs_device #(.MS_CYCLES(20)) u_pfs_device (.aclk(aclk), .aresetn(aresetn),
    .link(link.device), .enable(enable), .vin_level(vin),
    .temp_level(temp), .iout_level(iout), .vout_level(vout),
    .vout_ov_event(vout_ev), .iout_oc_event(iout_ev),
    .input_undervoltage_flag(uv), .output_on(output_on), .ramping(ramping),
    .power_good(power_good), .summary_status(summary));
  pfs_host #(.HALF(8)) u_pfs_host (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .irq(irq), .link(link.host));
  pfs_chk u_pfs_chk (.aclk(aclk), .aresetn(aresetn), .lclk(link.lclk),
    .lsel(link.lsel), .ldo(link.ldo), .ldi(link.ldi));
  always #4 aclk = ~aclk;
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string s, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : axi_rd
  // Frame via host, check result
  task automatic link_op(input logic [25:0] f);
    axi_wr(pfs_pkg::A_CMD, {f[16:1], 7'h00, f[25:17]});
    do @(posedge aclk); while (irq !== 1'b1);
    axi_rd(pfs_pkg::A_RESULT);
    chk("ack", 16'(f[0]), 16'(d[16]));
    if (f[25]) chk("data", f[16:1], d[15:0]);
    axi_wr(pfs_pkg::A_IRQ_ST, 32'h3);
  endtask : link_op
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    tally_and_finish();
  end
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_wr(pfs_pkg::A_IRQ_MASK, 32'h1);
    for (int i = 0; i < 38; i++) link_op(rows[i]);
    axi_wr(4'h2, 32'h0);
    chk("bresp", 16'(pfs_pkg::RESP_SLVERR), 16'(r));
    axi_rd(4'h2);
    chk("rdata", 16'h0000, d[15:0]);
    chk("rresp", 16'(pfs_pkg::RESP_SLVERR), 16'(r));
    axi_wr(pfs_pkg::A_IRQ_MASK, 32'h0);
    axi_wr(pfs_pkg::A_CMD, 32'h00000179);
    do axi_rd(pfs_pkg::A_IRQ_ST); while (d[0] !== 1'b1);
    chk("irq_masked", 16'h0000, 16'(irq));
    axi_wr(pfs_pkg::A_IRQ_MASK, 32'h1);
    @(posedge aclk);
    chk("irq_on", 16'h0001, 16'(irq));
    axi_wr(pfs_pkg::A_IRQ_ST, 32'h3);
    @(posedge aclk);
    chk("irq_clr", 16'h0000, 16'(irq));
    enable <= 1'b1;
    vout <= 16'h0084;
    repeat (3) @(posedge aclk);
    chk("ramping", 16'h0001, 16'(ramping));
    for (n = 0; n < 1000 && output_on !== 1'b1; n++) @(posedge aclk);
    chk("output_on", 16'h0001, 16'(output_on));
    chk("summary_on", 16'h0802, summary);
    @(posedge aclk);
    chk("power_good", 16'h0001, 16'(power_good));
    vin <= 16'h005b;
    for (n = 0; n < 20 && output_on !== 1'b0; n++) @(posedge aclk);
    chk("output_trip", 16'h0000, 16'(output_on));
    chk("input_bit", 16'h0001, 16'(summary[13]));
    enable <= 1'b0;
    vin <= 16'h0000;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("summary_rst", 16'h0840, summary);
    axi_wr(pfs_pkg::A_IRQ_MASK, 32'h1);
    link_op({1'b1, 8'h56, 16'h00c0, 1'b1});
    vout_ev <= 1'b1;
    iout_ev <= 1'b1;
    uv <= 1'b1;
    temp <= 16'h006e;
    iout <= 16'h00fb;
    @(posedge aclk);
    vout_ev <= 1'b0;
    iout_ev <= 1'b0;
    @(posedge aclk);
    chk("summary_ev", 16'hc87c, summary);
    link_op({1'b1, 8'h7a, 16'h0080, 1'b1});
    link_op({1'b1, 8'h7b, 16'h00a0, 1'b1});
    iout <= 16'h0000;
    link_op({1'b0, 8'h7b, 16'h0020, 1'b1});
    link_op({1'b1, 8'h7b, 16'h0080, 1'b1});
    link_op({1'b0, 8'h7b, 16'h0080, 1'b1});
    link_op({1'b0, 8'h7a, 16'h0080, 1'b1});
    uv <= 1'b0;
    @(posedge aclk);
    chk("summary_clr", 16'h0844, summary);
    tally_and_finish();
  end
endmodule : power_fault_status_regs_tb
